/* rtl/pgsr_regs.sv */
/*
 Register bank of a fractional-N synthesizer: output pin source and driver
 control, slip prevention settings, thermal sensor control and readout,
 and lock, overflow and sweep status with a sticky interrupt.
 Assumes a plain register port in the clock domain; analog sources arrive
 as synchronous levels.
*/
`timescale 1ns/1ps
`include "pgsr_params.svh"
module pgsr_regs
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic [5:0] reg_addr,
	input wire logic [23:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [23:0] reg_rdata,
	input wire logic loop_locked,
	input wire logic [2:0] modulator_overflow_flags,
	input wire logic sweep_active_flag,
	input wire logic [6:0] thermal_code,
	input wire logic thermal_code_valid,
	input wire logic main_slip_enable,
	input wire logic [2:0] clock_sources,
	input wire logic [2:0] detector_pulses,
	input wire logic ref_saturated,
	input wire logic div_saturated,
	input wire logic [2:0] ref_sources,
	input wire logic [3:0] modulator_integrator_state,
	input wire logic [2:0] aux_sources,
	input wire logic [2:0] quantizer_lsbs,
	output logic [2:0] general_output_pin_out,
	output logic [2:0] general_output_pin_oe_n,
	output logic [3:0] slip_prevention_step,
	output logic slip_prevention_active,
	output logic detector_reset_n,
	output logic charge_pump_hiz,
	output logic thermal_enable,
	output logic irq
);
	logic [10:0] pin_ctrl;
	logic [5:0] slip_ctrl;
	logic therm_ctrl;
	logic [6:0] therm_value;
	logic [`PGSR_EVT_W-1:0] irq_status;
	logic [`PGSR_EVT_W-1:0] irq_mask;
	logic locked_q;
	logic sweep_q;
	logic gain_strobe;
	logic [2:0] pins_q;
	pgsr_pkg::pgsr_det_state_t det_state;
	pgsr_pkg::pgsr_det_state_t next_det_state;
	pgsr_mux_if mx ();

	// Offset match, shared by every write strobe
	function automatic logic addr_hit(input logic [5:0] a, input logic [5:0] off);
		return a == off;
	endfunction

	// Write decode; reserved and read-only offsets get no strobe
	wire wr_pin = reg_write && addr_hit(reg_addr, `PGSR_OFF_PIN_CTRL);
	wire wr_slip = reg_write && addr_hit(reg_addr, `PGSR_OFF_SLIP_CTRL);
	wire wr_therm = reg_write && addr_hit(reg_addr, `PGSR_OFF_THERM_CTRL);
	wire wr_istat = reg_write && addr_hit(reg_addr, `PGSR_OFF_IRQ_STATUS);
	wire wr_imask = reg_write && addr_hit(reg_addr, `PGSR_OFF_IRQ_MASK);

	// Fields
	wire [3:0] sel = pin_ctrl[`PGSR_SEL_LSB +: 4];
	wire drive_en = pin_ctrl[`PGSR_DRIVE_EN_BIT];
	wire [2:0] pin_dis = pin_ctrl[`PGSR_DIS_LSB +: 3];
	wire [3:0] step = slip_ctrl[`PGSR_STEP_LSB +: 4];
	wire det_force = slip_ctrl[`PGSR_FORCE_BIT];
	wire det_rstb = slip_ctrl[`PGSR_RSTB_BIT];

	// Prevention needs a nonzero step, reset-bar and the main enable
	wire slip_on = (step != 4'h0) && det_rstb && main_slip_enable;
	// Strobe holding detector gain at max while a saturation is seen
	assign gain_strobe = slip_on && (ref_saturated || div_saturated);

	// Events for sticky status
	wire [`PGSR_EVT_W-1:0] events = {
		sweep_q && !sweep_active_flag,
		|modulator_overflow_flags,
		locked_q && !loop_locked,
		!locked_q && loop_locked
	};

	// Mux sources
	assign mx.sel = sel;
	assign mx.static_value = pin_ctrl[`PGSR_STATIC_LSB +: 3];
	assign mx.clocks = clock_sources;
	assign mx.updown = detector_pulses;
	assign mx.sat = {ref_saturated, div_saturated, gain_strobe};
	assign mx.refs = ref_sources;
	assign mx.integ = modulator_integrator_state;
	assign mx.aux = aux_sources;
	assign mx.sweep = sweep_active_flag;
	assign mx.quant = quantizer_lsbs;

	pgsr_pin_mux u_mux
	(
		.m(mx)
	);

	// Registered pin data
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			pins_q <= 3'h0;
		else
			pins_q <= mx.pins;
	end
	assign general_output_pin_out = pins_q;
	// Low enable means driven; master bit gates all pads, then each pad's own disable
	wire [2:0] pad_float;
	genvar pad;
	generate
		for (pad = 0; pad < 3; pad++)
		begin : g_pad
			assign pad_float[pad] = !(drive_en && !pin_dis[pad]);
		end
	endgenerate
	assign general_output_pin_oe_n = pad_float;

	// Control registers; widths stop at documented fields
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_ctrl <= 11'h000;
			slip_ctrl <= `PGSR_RST_SLIP;
			therm_ctrl <= 1'b0;
			irq_mask <= 4'h0;
		end
		else
		begin
			if (wr_pin)
				pin_ctrl <= reg_wdata[10:0];
			if (wr_slip)
				slip_ctrl <= reg_wdata[5:0];
			if (wr_therm)
				therm_ctrl <= reg_wdata[0];
			if (wr_imask)
				irq_mask <= reg_wdata[`PGSR_EVT_W-1:0];
		end
	end

	// Sticky status: a new event wins over a write-one clear
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			irq_status <= 4'h0;
		else
			irq_status <= (irq_status & ~(wr_istat ? reg_wdata[3:0] : 4'h0)) | events;
	end
	assign irq = |(irq_status & irq_mask);

	// Previous levels for edge events
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			locked_q <= 1'b0;
			sweep_q <= 1'b0;
		end
		else
		begin
			locked_q <= loop_locked;
			sweep_q <= sweep_active_flag;
		end
	end

	// Thermal code held until a fresh one arrives with the sensor enabled
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			therm_value <= `PGSR_RST_THERM;
		else if (thermal_code_valid && therm_ctrl)
			therm_value <= thermal_code;
	end

	// Detector reset control state
	always_comb
	begin
		case (1'b1)
			det_force && !det_rstb: next_det_state = pgsr_pkg::PGSR_DET_HELD;
			det_force: next_det_state = pgsr_pkg::PGSR_DET_RUN;
			default: next_det_state = pgsr_pkg::PGSR_DET_AUTO;
		endcase
	end
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			det_state <= pgsr_pkg::PGSR_DET_AUTO;
		else
			det_state <= next_det_state;
	end

	// Detector reset and loop opening
	always_comb
	begin
		case (det_state)
			pgsr_pkg::PGSR_DET_HELD: detector_reset_n = 1'b0;
			pgsr_pkg::PGSR_DET_RUN: detector_reset_n = 1'b1;
			pgsr_pkg::PGSR_DET_AUTO: detector_reset_n = !gain_strobe; // Auto: prevention logic
			default: detector_reset_n = 1'b1;
		endcase
	end
	// Forced reset tri-states the pump, freezing filter charge
	assign charge_pump_hiz = (det_state == pgsr_pkg::PGSR_DET_HELD);
	assign slip_prevention_step = slip_on ? step : 4'h0;
	assign slip_prevention_active = slip_on;
	assign thermal_enable = therm_ctrl;

	// Read mux; unmapped and reserved offsets read their defaults
	logic [23:0] rd_mux;
	always_comb
	begin
		case (reg_addr)
			`PGSR_OFF_PIN_CTRL: rd_mux = {13'h0000, pin_ctrl};
			`PGSR_OFF_SLIP_CTRL: rd_mux = {18'h00000, slip_ctrl};
			`PGSR_OFF_THERM_CTRL: rd_mux = {23'h000000, therm_ctrl};
			`PGSR_OFF_STATUS: rd_mux = {18'h00000, sweep_active_flag, 1'b0,
				modulator_overflow_flags, loop_locked};
			`PGSR_OFF_RSVD_B: rd_mux = `PGSR_RST_RSVD_B;
			`PGSR_OFF_THERM_READ: rd_mux = {17'h00000, therm_value};
			`PGSR_OFF_IRQ_STATUS: rd_mux = {20'h00000, irq_status};
			`PGSR_OFF_IRQ_MASK: rd_mux = {20'h00000, irq_mask};
			default: rd_mux = 24'h000000;
		endcase
	end
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			reg_rdata <= 24'h000000;
		else if (reg_read)
			reg_rdata <= rd_mux;
		else
			reg_rdata <= 24'h000000;
	end

	// Checks
	sequence s_force_low;
		slip_ctrl[`PGSR_FORCE_BIT] && !slip_ctrl[`PGSR_RSTB_BIT];
	endsequence
	// Override clear for two cycles, so the state has settled to automatic
	sequence s_auto_held;
		!slip_ctrl[`PGSR_FORCE_BIT] ##1 !slip_ctrl[`PGSR_FORCE_BIT];
	endsequence
	// Prevention on and a saturation seen while the saturation set is selected
	sequence s_strobe_cond;
		sel == `PGSR_SEL_SAT && slip_prevention_active && (ref_saturated || div_saturated);
	endsequence
	// Pin sources, one cycle behind the selector
	a_static_pins: assert property (@(posedge clock) disable iff (!resetn)
		sel == `PGSR_SEL_STATIC |=> pins_q == $past(pin_ctrl[6:4]))
		else $error("static value not on pins");
	a_phase_order: assert property (@(posedge clock) disable iff (!resetn)
		sel == `PGSR_SEL_PHASE |=> pins_q[0] == $past(modulator_integrator_state[3])
		&& pins_q[2] == $past(modulator_integrator_state[1]))
		else $error("phase bit order wrong");
	a_undef_low: assert property (@(posedge clock) disable iff (!resetn)
		(sel == `PGSR_SEL_RSVD5 || sel == `PGSR_SEL_UNUSED9) |=> pins_q == 3'h0)
		else $error("undefined selector drives pins");
	a_sat_pins: assert property (@(posedge clock) disable iff (!resetn)
		sel == `PGSR_SEL_SAT |=> pins_q[2] == $past(ref_saturated)
		&& pins_q[1] == $past(div_saturated))
		else $error("saturation signals not on pins");
	a_strobe_pin: assert property (@(posedge clock) disable iff (!resetn)
		s_strobe_cond |=> pins_q[0])
		else $error("gain strobe not on pin 1");
	a_clock_pins: assert property (@(posedge clock) disable iff (!resetn)
		sel == `PGSR_SEL_CLOCKS |=> pins_q == $past(clock_sources))
		else $error("clock sources not on pins");
	a_pulse_pins: assert property (@(posedge clock) disable iff (!resetn)
		sel == `PGSR_SEL_UPDOWN |=> pins_q == $past(detector_pulses))
		else $error("detector pulses not on pins");
	a_ref_pins: assert property (@(posedge clock) disable iff (!resetn)
		sel == `PGSR_SEL_REFS |=> pins_q == $past(ref_sources))
		else $error("reference sources not on pins");
	a_aux_pins: assert property (@(posedge clock) disable iff (!resetn)
		sel == `PGSR_SEL_AUX |=> pins_q == $past(aux_sources))
		else $error("aux sources not on pins");
	a_sweep_pin: assert property (@(posedge clock) disable iff (!resetn)
		sel == `PGSR_SEL_SWEEP |=> pins_q == {1'b0, $past(sweep_active_flag), 1'b0})
		else $error("sweep flag not on pin 2");
	a_quant_pins: assert property (@(posedge clock) disable iff (!resetn)
		sel == `PGSR_SEL_QUANT |=> pins_q == $past(quantizer_lsbs))
		else $error("quantizer bits not on pins");
	// Pad enables follow the driver bits at once
	a_pad_hiz: assert property (@(posedge clock) disable iff (!resetn)
		!pin_ctrl[7] |-> general_output_pin_oe_n == 3'h7)
		else $error("pad driven while disabled");
	a_pad_driven: assert property (@(posedge clock) disable iff (!resetn)
		pin_ctrl[`PGSR_DRIVE_EN_BIT] && !pin_ctrl[`PGSR_DIS_LSB]
		|-> !general_output_pin_oe_n[0])
		else $error("pin 1 not driven while enabled");
	a_pin_disable: assert property (@(posedge clock) disable iff (!resetn)
		wr_pin && reg_wdata[7] && reg_wdata[8] |=> general_output_pin_oe_n[0])
		else $error("pin 1 disable ignored");
	// Detector reset, forced and automatic
	a_force_reset: assert property (@(posedge clock) disable iff (!resetn)
		s_force_low |=> !detector_reset_n && charge_pump_hiz)
		else $error("forced reset not applied");
	a_force_run: assert property (@(posedge clock) disable iff (!resetn)
		slip_ctrl[`PGSR_FORCE_BIT] && slip_ctrl[`PGSR_RSTB_BIT] |=> detector_reset_n)
		else $error("forced run not applied");
	a_auto_reset: assert property (@(posedge clock) disable iff (!resetn)
		s_auto_held |-> detector_reset_n ==
		!(slip_prevention_active && (ref_saturated || div_saturated)))
		else $error("automatic detector reset wrong");
	a_loop_closed: assert property (@(posedge clock) disable iff (!resetn)
		!(slip_ctrl[`PGSR_FORCE_BIT] && !slip_ctrl[`PGSR_RSTB_BIT]) |=> !charge_pump_hiz)
		else $error("pump floated without forced reset");
	// Slip step and its enables
	a_step_zero: assert property (@(posedge clock) disable iff (!resetn)
		step == 4'h0 |-> !slip_prevention_active)
		else $error("prevention on with zero step");
	a_step_out: assert property (@(posedge clock) disable iff (!resetn)
		slip_prevention_active |-> slip_prevention_step == slip_ctrl[3:0])
		else $error("step not passed through");
	a_need_main: assert property (@(posedge clock) disable iff (!resetn)
		!main_slip_enable |-> slip_prevention_step == 4'h0)
		else $error("prevention without main enable");
	// Thermal code moves only on a fresh code with the sensor enabled
	a_therm_take: assert property (@(posedge clock) disable iff (!resetn)
		thermal_code_valid && thermal_enable |=> therm_value == $past(thermal_code))
		else $error("thermal code not captured");
	a_therm_hold: assert property (@(posedge clock) disable iff (!resetn)
		!(thermal_code_valid && thermal_enable) |=> therm_value == $past(therm_value))
		else $error("thermal code moved while idle");
	// Status read back one cycle after the strobe
	a_status_read: assert property (@(posedge clock) disable iff (!resetn)
		reg_read && reg_addr == `PGSR_OFF_STATUS |=> reg_rdata[0] == $past(loop_locked)
		&& reg_rdata[3:1] == $past(modulator_overflow_flags)
		&& reg_rdata[5] == $past(sweep_active_flag))
		else $error("status read wrong");
endmodule

/* rtl/pgsr_params.svh */
/*
 Offsets, field positions, reset values and codes for the output pin,
 slip prevention, thermal and status register bank.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef PGSR_PARAMS_SVH
`define PGSR_PARAMS_SVH

// Register offsets (word addresses on the plain register port)
`define PGSR_OFF_PIN_CTRL 6'h1b
`define PGSR_OFF_SLIP_CTRL 6'h1c
`define PGSR_OFF_RSVD_A 6'h1d
`define PGSR_OFF_THERM_CTRL 6'h1e
`define PGSR_OFF_STATUS 6'h1f
`define PGSR_OFF_RSVD_B 6'h20
`define PGSR_OFF_THERM_READ 6'h21
`define PGSR_OFF_RSVD_C 6'h22
`define PGSR_OFF_IRQ_STATUS 6'h23
`define PGSR_OFF_IRQ_MASK 6'h24

// Reset values
`define PGSR_RST_RSVD_B 24'h000020
`define PGSR_RST_THERM 7'h1f
`define PGSR_RST_SLIP 6'h20

// Output pin control fields
`define PGSR_SEL_LSB 0
`define PGSR_STATIC_LSB 4
`define PGSR_DRIVE_EN_BIT 7
`define PGSR_DIS_LSB 8

// Slip prevention fields
`define PGSR_STEP_LSB 0
`define PGSR_FORCE_BIT 4
`define PGSR_RSTB_BIT 5

// Selector codes
`define PGSR_SEL_STATIC 4'h0
`define PGSR_SEL_CLOCKS 4'h1
`define PGSR_SEL_UPDOWN 4'h2
`define PGSR_SEL_SAT 4'h3
`define PGSR_SEL_REFS 4'h4
`define PGSR_SEL_RSVD5 4'h5
`define PGSR_SEL_PHASE 4'h6
`define PGSR_SEL_AUX 4'h7
`define PGSR_SEL_SWEEP 4'h8
`define PGSR_SEL_UNUSED9 4'h9
`define PGSR_SEL_QUANT 4'ha

// Interrupt event bits: lock gained, lock lost, overflow, sweep end
`define PGSR_EVT_W 4
`define PGSR_EVT_LOCK 0
`define PGSR_EVT_UNLOCK 1
`define PGSR_EVT_OVF 2
`define PGSR_EVT_SWEEP_END 3

`endif

/* rtl/pgsr_pkg.sv */
/*
 Types for the register bank; its pin multiplexer uses none of them.
 Assumes the params header is compiled alongside.
*/
package pgsr_pkg;
	typedef logic [2:0] pgsr_pins_t;
	typedef enum logic [2:0] {
		PGSR_DET_AUTO = 3'h1,
		PGSR_DET_HELD = 3'h2,
		PGSR_DET_RUN = 3'h4
	} pgsr_det_state_t;
endpackage

/* rtl/pgsr_mux_if.sv */
/*
 Interface between the register bank and the output pin multiplexer.
 Assumes a single clock domain; carries only combinational levels.
*/
`timescale 1ns/1ps
interface pgsr_mux_if;
	logic [3:0] sel;
	logic [2:0] static_value;
	logic [2:0] clocks;
	logic [2:0] updown;
	logic [2:0] sat;
	logic [2:0] refs;
	logic [3:0] integ;
	logic [2:0] aux;
	logic sweep;
	logic [2:0] quant;
	logic [2:0] pins;
	modport bank (output sel, static_value, clocks, updown, sat, refs, integ, aux,
		sweep, quant, input pins);
	modport mux (input sel, static_value, clocks, updown, sat, refs, integ, aux,
		sweep, quant, output pins);
endinterface

/* rtl/pgsr_pin_mux.sv */
/*
 Output source multiplexer for the three general output pins.
 Assumes all sources are already levels in the clock domain.
*/
`timescale 1ns/1ps
`include "pgsr_params.svh"
module pgsr_pin_mux
(
	pgsr_mux_if.mux m
);
	// Bit 2 goes to pin 3, bit 0 to pin 1
	always_comb
	begin
		case (m.sel)
			`PGSR_SEL_STATIC: m.pins = m.static_value;
			`PGSR_SEL_CLOCKS: m.pins = m.clocks;
			`PGSR_SEL_UPDOWN: m.pins = m.updown;
			`PGSR_SEL_SAT: m.pins = m.sat;
			`PGSR_SEL_REFS: m.pins = m.refs;
			`PGSR_SEL_PHASE: m.pins = {m.integ[1], m.integ[2], m.integ[3]};
			`PGSR_SEL_AUX: m.pins = m.aux;
			`PGSR_SEL_SWEEP: m.pins = {1'b0, m.sweep, 1'b0};
			`PGSR_SEL_QUANT: m.pins = m.quant;
			default: m.pins = 3'h0; // Codes 5 and 9 undefined: drive low
		endcase
	end
endmodule

/* tb/pll_gpo_status_regs_tb_top.sv */
/*
 Self-checking bench for the output pin, slip and status register bank.
 Assumes pgsr_regs and its params header; the bench drives every port itself.
*/
`timescale 1ns/1ps
`include "pgsr_params.svh"
module pll_gpo_status_regs_tb_top;
logic clock, resetn, reg_write, reg_read, loop_locked, sweep_active_flag, thermal_code_valid;
logic main_slip_enable, ref_saturated, div_saturated, slip_prevention_active;
logic detector_reset_n, charge_pump_hiz, thermal_enable, irq;
logic [5:0] reg_addr;
logic [23:0] reg_wdata, reg_rdata, rd;
logic [6:0] thermal_code;
logic [3:0] modulator_integrator_state, slip_prevention_step, step;
logic [2:0] modulator_overflow_flags, clock_sources, detector_pulses, ref_sources, aux_sources;
logic [2:0] quantizer_lsbs, general_output_pin_out, general_output_pin_oe_n, sv;
logic [15:0] seed;
logic force_bit, rstb;
int err_total, num_checks;
pgsr_regs uut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.loop_locked(loop_locked), .modulator_overflow_flags(modulator_overflow_flags),
	.sweep_active_flag(sweep_active_flag), .thermal_code(thermal_code),
	.thermal_code_valid(thermal_code_valid), .main_slip_enable(main_slip_enable),
	.clock_sources(clock_sources), .detector_pulses(detector_pulses),
	.ref_saturated(ref_saturated), .div_saturated(div_saturated), .ref_sources(ref_sources),
	.modulator_integrator_state(modulator_integrator_state), .aux_sources(aux_sources),
	.quantizer_lsbs(quantizer_lsbs), .general_output_pin_out(general_output_pin_out),
	.general_output_pin_oe_n(general_output_pin_oe_n),
	.slip_prevention_step(slip_prevention_step),
	.slip_prevention_active(slip_prevention_active), .detector_reset_n(detector_reset_n),
	.charge_pump_hiz(charge_pump_hiz), .thermal_enable(thermal_enable), .irq(irq));
// Clock, 100 ns period
initial
begin
	clock = 1'b0;
	forever #50 clock = ~clock;
end
task automatic summarize();
	if (err_total == 0 && num_checks > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
endtask
task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
	num_checks++;
	if (seen !== exp)
	begin
		err_total++;
		$display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
	end
endtask
// Sixteen-bit shift register, repeatable from its start value
function automatic logic [15:0] lfsr_next(input logic [15:0] s);
	return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
endfunction
task automatic draw();
	seed = lfsr_next(lfsr_next(lfsr_next(seed)));
endtask
task automatic tick(input int n);
	repeat (n) @(posedge clock);
endtask
task automatic wr(input logic [5:0] a, input logic [23:0] d);
	@(posedge clock);
	reg_write <= 1'b1;
	reg_addr <= a;
	reg_wdata <= d;
	@(posedge clock);
	reg_write <= 1'b0;
endtask
// Read data stands only in the cycle after the strobe, so sample there
task automatic rdc(input logic [5:0] a, input logic [23:0] exp, input string msg);
	@(posedge clock);
	reg_read <= 1'b1;
	reg_addr <= a;
	@(posedge clock);
	reg_read <= 1'b0;
	#1;
	check(reg_rdata, exp, msg);
endtask
// Pin levels expected for a selector, with slip prevention kept off
function automatic logic [2:0] exp_pins(input logic [3:0] s, input logic [2:0] st);
	case (s)
		`PGSR_SEL_STATIC: return st;
		`PGSR_SEL_CLOCKS: return clock_sources;
		`PGSR_SEL_UPDOWN: return detector_pulses;
		`PGSR_SEL_SAT: return {ref_saturated, div_saturated, 1'b0};
		`PGSR_SEL_REFS: return ref_sources;
		`PGSR_SEL_PHASE: return {modulator_integrator_state[1], modulator_integrator_state[2],
			modulator_integrator_state[3]};
		`PGSR_SEL_AUX: return aux_sources;
		`PGSR_SEL_SWEEP: return {1'b0, sweep_active_flag, 1'b0};
		`PGSR_SEL_QUANT: return quantizer_lsbs;
		default: return 3'h0;
	endcase
endfunction
// Hang guard: a run past this bound is a failure
initial
begin
	#5000000;
	err_total++;
	summarize();
end
// Main sequence
initial
begin
	{reg_write, reg_read, loop_locked, sweep_active_flag, thermal_code_valid} = 5'h0;
	{main_slip_enable, ref_saturated, div_saturated} = 3'h0;
	{reg_addr, reg_wdata, thermal_code, modulator_integrator_state} = '0;
	{modulator_overflow_flags, clock_sources, detector_pulses, ref_sources} = '0;
	{aux_sources, quantizer_lsbs} = '0;
	seed = 16'h005e;
	err_total = 0;
	num_checks = 0;
	resetn = 1'b0;
	tick(20);
	resetn <= 1'b1;
	check(general_output_pin_oe_n, 24'h7, "pads float after reset");
	rdc(`PGSR_OFF_SLIP_CTRL, 24'h20, "slip reset");
	rdc(`PGSR_OFF_RSVD_A, 24'h0, "reserved a");
	rdc(`PGSR_OFF_RSVD_B, 24'h20, "reserved b");
	rdc(`PGSR_OFF_THERM_READ, 24'h1f, "thermal reset");
	@(posedge clock);
	#1;
	check(reg_rdata, 24'h0, "read data one cycle only");
	rdc(`PGSR_OFF_STATUS, 24'h0, "status reset");
	rdc(6'h3f, 24'h0, "unmapped read");
	// Selector codes 0 to 10, sources redrawn each time
	for (int s = 0; s < 11; s++)
	begin
		draw();
		@(posedge clock);
		{clock_sources, detector_pulses, ref_sources, aux_sources, quantizer_lsbs} <= seed[14:0];
		{ref_saturated, div_saturated, sweep_active_flag} <= seed[15:13];
		modulator_integrator_state <= seed[3:0] ^ seed[15:12];
		sv = seed[7:5];
		wr(`PGSR_OFF_PIN_CTRL, {16'h0, 1'b1, sv, 4'(s)});
		tick(3);
		check(general_output_pin_out, exp_pins(4'(s), sv), "pin source");
		check(general_output_pin_oe_n, 24'h0, "all pads driven");
	end
	// Driver enable and per-pin disable
	for (int d = 0; d < 16; d++)
	begin
		wr(`PGSR_OFF_PIN_CTRL, {13'h0, 3'(d), d[3], 7'h0});
		tick(2);
		check(general_output_pin_oe_n, d[3] ? 24'(d[2:0]) : 24'h7, "pad enables");
		rdc(`PGSR_OFF_PIN_CTRL, {13'h0, 3'(d), d[3], 7'h0}, "pin ctrl readback");
	end
	// Slip step, override and detector reset
	for (int k = 0; k < 12; k++)
	begin
		draw();
		step = seed[3:0];
		force_bit = seed[4];
		rstb = seed[5];
		@(posedge clock);
		main_slip_enable <= seed[6];
		wr(`PGSR_OFF_SLIP_CTRL, {18'h0, rstb, force_bit, step});
		tick(3);
		check(slip_prevention_active, (step != 0) && rstb && main_slip_enable, "active");
		check(slip_prevention_step, ((step != 0) && rstb && main_slip_enable) ? step : 4'h0,
			"step out");
		check(charge_pump_hiz, force_bit && !rstb, "pump hiz");
		if (force_bit)
			check(detector_reset_n, rstb, "forced reset");
	end
	// Saturation with prevention on: gain strobe on pin 1, automatic detector reset
	@(posedge clock);
	main_slip_enable <= 1'b1;
	ref_saturated <= 1'b1;
	div_saturated <= 1'b0;
	wr(`PGSR_OFF_SLIP_CTRL, 24'h23);
	wr(`PGSR_OFF_PIN_CTRL, 24'h83);
	tick(3);
	check(general_output_pin_out, 24'h5, "gain strobe pin");
	check(detector_reset_n, 1'b0, "auto detector reset");
	check(charge_pump_hiz, 1'b0, "loop closed in auto");
	wr(`PGSR_OFF_SLIP_CTRL, 24'h0);
	// Earlier random sweep levels may have left sticky bits; start clean
	wr(`PGSR_OFF_IRQ_STATUS, 24'hf);
	// Interrupt on lock gained, clear, lock lost masked then unmasked
	wr(`PGSR_OFF_IRQ_MASK, 24'h1);
	@(posedge clock);
	loop_locked <= 1'b1;
	tick(3);
	check(irq, 1'b1, "irq lock gained");
	wr(`PGSR_OFF_IRQ_STATUS, 24'h1);
	tick(2);
	check(irq, 1'b0, "irq cleared");
	loop_locked <= 1'b0;
	tick(3);
	check(irq, 1'b0, "irq masked");
	rdc(`PGSR_OFF_IRQ_STATUS, 24'h2, "irq status");
	wr(`PGSR_OFF_IRQ_MASK, 24'h2);
	tick(2);
	check(irq, 1'b1, "irq unmasked");
	wr(`PGSR_OFF_IRQ_STATUS, 24'h2);
	tick(2);
	check(irq, 1'b0, "irq cleared again");
	// Status flags under random levels
	for (int k = 0; k < 6; k++)
	begin
		draw();
		@(posedge clock);
		{loop_locked, modulator_overflow_flags, sweep_active_flag} <= seed[4:0];
		tick(3);
		rdc(`PGSR_OFF_STATUS, {18'h0, seed[0], 1'b0, seed[3:1], seed[4]}, "status");
	end
	// Thermal capture only while the sensor is enabled; readout is read-only
	wr(`PGSR_OFF_THERM_CTRL, 24'h1);
	tick(2);
	check(thermal_enable, 1'b1, "sensor enable");
	draw();
	@(posedge clock);
	thermal_code <= seed[6:0];
	thermal_code_valid <= 1'b1;
	@(posedge clock);
	thermal_code_valid <= 1'b0;
	tick(2);
	rdc(`PGSR_OFF_THERM_READ, {17'h0, seed[6:0]}, "thermal code");
	wr(`PGSR_OFF_THERM_READ, 24'h0);
	wr(`PGSR_OFF_RSVD_A, 24'hffffff);
	wr(`PGSR_OFF_THERM_CTRL, 24'h0);
	@(posedge clock);
	thermal_code <= ~seed[6:0];
	thermal_code_valid <= 1'b1;
	@(posedge clock);
	thermal_code_valid <= 1'b0;
	tick(2);
	rdc(`PGSR_OFF_THERM_READ, {17'h0, seed[6:0]}, "thermal held");
	rdc(`PGSR_OFF_RSVD_A, 24'h0, "reserved write ignored");
	summarize();
end
endmodule
